// file: src/isf_pkg.sv
// constants, types and word formatting for the image sync framer
// assumes one system clock; all users refer to items as isf_pkg::name
// What this block does
// - data lanes carry pixels, sync lane describes
// - wide mode: ten-bit words, 620 Mbps lanes
// - narrow mode: eight-bit words, 496 Mbps lanes
// - narrow frame layout equals wide layout
// - dark lines first, then window lines
// - overlapping windows share lines in order
// - sync lane describes data concurrently
// - line start and line end codes
// - first/last window line use frame codes
// - window number follows every sync code
// - only highest overlapping window gets codes
// - wide code bits 9:7 encode event
// - wide bits 6:0 carry programmable marker
// - wide window number in bits 2:0
// - other cycles send classification codes
// - idle: data lanes send training pattern
// - narrow: drop two lsbs, id bits 4:2
package isf_pkg;
   // word geometry and lane rates
   localparam int WORD_W = 10;
   localparam int NARROW_W = 8;
   localparam int LANES = 4;
   localparam int LANE_RATE_WIDE_MBPS = 620;
   localparam int LANE_RATE_NARROW_MBPS = 496;
   // both modes keep the same word rate, only depth changes
   localparam int WORD_RATE_MHZ = LANE_RATE_WIDE_MBPS / WORD_W;
   localparam int WIN_N = 8;

   // register offsets
   localparam logic [7:0] REG_TRAIN = 8'h82;
   localparam logic [7:0] REG_MARKER = 8'h83;
   localparam logic [7:0] REG_DARK = 8'h84;
   localparam logic [7:0] REG_VALID = 8'h85;
   localparam logic [7:0] REG_CRC = 8'h86;
   localparam logic [7:0] REG_IDLE = 8'h87;
   localparam logic [7:0] REG_MODE = 8'h88;
   localparam logic [7:0] REG_STATUS = 8'h89;

   // reset values
   localparam logic [9:0] RST_TRAIN = 10'h3a6;
   localparam logic [6:0] RST_MARKER = 7'h2a;
   localparam logic [9:0] RST_DARK = 10'h015;
   localparam logic [9:0] RST_VALID = 10'h035;
   localparam logic [9:0] RST_CRC = 10'h059;
   localparam logic [9:0] RST_IDLE = 10'h3a6;

   // event codes in the top three bits of a sync word
   localparam logic [2:0] CODE_FS = 3'h5;
   localparam logic [2:0] CODE_FE = 3'h6;
   localparam logic [2:0] CODE_LS = 3'h1;
   localparam logic [2:0] CODE_LE = 3'h2;

   typedef enum logic [1:0] {
      KIND_DARK = 2'h0,
      KIND_VALID = 2'h1,
      KIND_CRC = 2'h2
   } isf_kind_t;

   // gray codes along idle -> start -> id -> data -> end -> id
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_SCODE = 3'h1,
      ST_SID = 3'h3,
      ST_DATA = 3'h2,
      ST_ECODE = 3'h6,
      ST_EID = 3'h7
   } isf_state_t;

   // sync word: code then marker, narrow drops marker lsbs
   function automatic logic [9:0] fmt_sync(input logic [2:0] code, input logic [6:0] mark,
                                           input logic narrow);
      if (narrow) begin
         fmt_sync = {2'h0, code, mark[6:2]};
      end else begin
         fmt_sync = {code, mark};
      end
   endfunction

   // window number word following a sync code
   function automatic logic [9:0] fmt_id(input logic [2:0] id, input logic narrow);
      if (narrow) begin
         fmt_id = {5'h00, id, 2'h0};
      end else begin
         fmt_id = {7'h00, id};
      end
   endfunction

   // ten-bit value shrunk to eight significant bits in narrow mode
   function automatic logic [9:0] fit(input logic [9:0] v, input logic narrow);
      fit = narrow ? {2'h0, v[9:2]} : v;
   endfunction

   // highest active window wins
   function automatic logic [2:0] top_win(input logic [7:0] mask);
      top_win = 3'h0;
      for (int i = 0; i < WIN_N; i++) begin
         if (mask[i]) begin
            top_win = i[2:0];
         end
      end
   endfunction
endpackage

// file: src/isf_edge_sync.sv
// two-flop synchroniser with rising-edge pulse for the word-slot clock
// assumes the input is asynchronous and far slower than clk_sys_in
`timescale 1ns/1ps
module isf_edge_sync (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   // asynchronous level
   input wire logic async_in,
   // one-cycle pulse per rising edge
   output logic rise_out
);
   logic meta_ff;
   logic sync_ff;
   logic last_ff;

   // only sync_ff reads meta_ff
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         last_ff <= 1'b0;
         rise_out <= 1'b0;
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
         last_ff <= sync_ff;
         rise_out <= sync_ff & ~last_ff;
      end
   end
endmodule

// file: src/isf_buf2.sv
// two-entry buffer with valid/ready on both sides
// assumes source and sink share clk_sys_in
`timescale 1ns/1ps
module isf_buf2 #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   // fill side
   input wire logic in_valid_in,
   input wire logic [W-1:0] in_data_in,
   output logic in_ready_out,
   // drain side
   output logic out_valid_out,
   output logic [W-1:0] out_data_out,
   input wire logic out_ready_in
);
   if (W < 1) begin : g_chk
      $error("buffer width must be positive");
   end

   logic [W-1:0] mem_ff [2];
   logic wp_ff;
   logic rp_ff;
   logic [1:0] cnt_ff;
   logic push;
   logic pop;
   logic [1:0] nxt_cnt;

   // ready is registered, so it lags a pop by one cycle
   assign push = in_valid_in & in_ready_out;
   assign pop = out_ready_in & (cnt_ff != 2'h0);
   assign nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
   assign out_valid_out = (cnt_ff != 2'h0);
   assign out_data_out = mem_ff[rp_ff];

   // pointers and fill level
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         wp_ff <= 1'b0;
         rp_ff <= 1'b0;
         cnt_ff <= 2'h0;
         in_ready_out <= 1'b0;
      end else begin
         wp_ff <= wp_ff ^ push;
         rp_ff <= rp_ff ^ pop;
         cnt_ff <= nxt_cnt;
         in_ready_out <= (nxt_cnt != 2'h2);
      end
   end

   // storage has no reset
   always_ff @(posedge clk_sys_in) begin
      if (push) begin
         mem_ff[wp_ff] <= in_data_in;
      end
   end
endmodule

// file: src/isf_framer.sv
// sync-lane framer: four pixel lanes, one sync lane, forwarded clock
// assumes the core delivers beats in line order with window flags
`timescale 1ns/1ps
module isf_framer (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   // register port
   input wire logic reg_wr_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   output logic [15:0] reg_rdata_out,
   // word-slot clock from the link side
   input wire logic link_clk_in,
   // pixel beats from the readout core
   input wire logic pix_valid_in,
   output logic pix_ready_out,
   input wire logic [9:0] pix_lane0_in,
   input wire logic [9:0] pix_lane1_in,
   input wire logic [9:0] pix_lane2_in,
   input wire logic [9:0] pix_lane3_in,
   input wire logic [1:0] pix_kind_in,
   input wire logic [7:0] pix_win_mask_in,
   input wire logic pix_line_first_in,
   input wire logic pix_line_last_in,
   input wire logic pix_win_top_in,
   input wire logic pix_win_bottom_in,
   // serial-side words
   output logic [9:0] lane0_out,
   output logic [9:0] lane1_out,
   output logic [9:0] lane2_out,
   output logic [9:0] lane3_out,
   output logic [9:0] sync_out,
   output logic fwd_clk_out
);
   localparam int BW = 56;

   logic slot;
   logic [BW-1:0] b_data;
   logic b_valid;
   logic b_ready;
   logic [39:0] b_pix;
   logic [1:0] b_kind;
   logic [7:0] b_mask;
   logic b_sol;
   logic b_eol;
   logic b_top;
   logic b_bot;
   logic win_beat;
   logic start_line;
   logic send_beat;
   logic [9:0] cfg_train_ff;
   logic [6:0] cfg_marker_ff;
   logic [9:0] cfg_dark_ff;
   logic [9:0] cfg_valid_ff;
   logic [9:0] cfg_crc_ff;
   logic [9:0] cfg_idle_ff;
   logic narrow_ff;
   isf_pkg::isf_state_t st_ff;
   isf_pkg::isf_state_t nxt_st;
   logic [2:0] id_ff;
   logic frame_edge_ff;
   logic [9:0] class_code;

   // slot pulse from the sampled link clock
   isf_edge_sync u_slot (
      .clk_sys_in(clk_sys_in),
      .reset_n_in(reset_n_in),
      .async_in(link_clk_in),
      .rise_out(slot)
   );

   // a receiver stall fills this before the core is held off
   isf_buf2 #(.W(BW)) u_buf (
      .clk_sys_in(clk_sys_in),
      .reset_n_in(reset_n_in),
      .in_valid_in(pix_valid_in),
      .in_data_in({2'h0, pix_lane3_in, pix_lane2_in, pix_lane1_in, pix_lane0_in, pix_kind_in,
                   pix_win_mask_in, pix_line_first_in, pix_line_last_in, pix_win_top_in,
                   pix_win_bottom_in}),
      .in_ready_out(pix_ready_out),
      .out_valid_out(b_valid),
      .out_data_out(b_data),
      .out_ready_in(b_ready)
   );

   // beat field split
   assign b_pix = b_data[53:14];
   assign b_kind = b_data[13:12];
   assign b_mask = b_data[11:4];
   assign b_sol = b_data[3];
   assign b_eol = b_data[2];
   assign b_top = b_data[1];
   assign b_bot = b_data[0];
   // dark lines carry no line codes, so they pass straight through
   assign win_beat = (b_kind != isf_pkg::KIND_DARK);
   assign start_line = (st_ff == isf_pkg::ST_IDLE) && b_valid && win_beat && b_sol;
   assign send_beat = b_valid && ((st_ff == isf_pkg::ST_DATA) || ((st_ff == isf_pkg::ST_IDLE) && !start_line));
   assign b_ready = slot && send_beat;

   // classification of the beat on the data lanes
   always_comb begin
      unique case (b_kind)
         isf_pkg::KIND_DARK: class_code = cfg_dark_ff;
         isf_pkg::KIND_VALID: class_code = cfg_valid_ff;
         isf_pkg::KIND_CRC: class_code = cfg_crc_ff;
         default: class_code = cfg_idle_ff;
      endcase
   end

   // register writes
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         cfg_train_ff <= isf_pkg::RST_TRAIN;
         cfg_marker_ff <= isf_pkg::RST_MARKER;
         cfg_dark_ff <= isf_pkg::RST_DARK;
         cfg_valid_ff <= isf_pkg::RST_VALID;
         cfg_crc_ff <= isf_pkg::RST_CRC;
         cfg_idle_ff <= isf_pkg::RST_IDLE;
         narrow_ff <= 1'b0;
      end else if (reg_wr_in) begin
         unique case (reg_addr_in)
            isf_pkg::REG_TRAIN: cfg_train_ff <= reg_wdata_in[9:0];
            isf_pkg::REG_MARKER: cfg_marker_ff <= reg_wdata_in[6:0];
            isf_pkg::REG_DARK: cfg_dark_ff <= reg_wdata_in[9:0];
            isf_pkg::REG_VALID: cfg_valid_ff <= reg_wdata_in[9:0];
            isf_pkg::REG_CRC: cfg_crc_ff <= reg_wdata_in[9:0];
            isf_pkg::REG_IDLE: cfg_idle_ff <= reg_wdata_in[9:0];
            isf_pkg::REG_MODE: narrow_ff <= reg_wdata_in[0];
            default: ;
         endcase
      end
   end

   // read-back, one cycle after the address
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         reg_rdata_out <= 16'h0000;
      end else begin
         unique case (reg_addr_in)
            isf_pkg::REG_TRAIN: reg_rdata_out <= {6'h00, cfg_train_ff};
            isf_pkg::REG_MARKER: reg_rdata_out <= {9'h000, cfg_marker_ff};
            isf_pkg::REG_DARK: reg_rdata_out <= {6'h00, cfg_dark_ff};
            isf_pkg::REG_VALID: reg_rdata_out <= {6'h00, cfg_valid_ff};
            isf_pkg::REG_CRC: reg_rdata_out <= {6'h00, cfg_crc_ff};
            isf_pkg::REG_IDLE: reg_rdata_out <= {6'h00, cfg_idle_ff};
            isf_pkg::REG_MODE: reg_rdata_out <= {15'h0000, narrow_ff};
            isf_pkg::REG_STATUS: reg_rdata_out <= {9'h000, b_valid, id_ff, st_ff};
            default: reg_rdata_out <= 16'h0000;
         endcase
      end
   end

   // sequence per window line: code, id, beats, code, id
   always_comb begin
      nxt_st = st_ff;
      unique case (st_ff)
         isf_pkg::ST_IDLE: if (start_line) nxt_st = isf_pkg::ST_SCODE;
         isf_pkg::ST_SCODE: nxt_st = isf_pkg::ST_SID;
         isf_pkg::ST_SID: nxt_st = isf_pkg::ST_DATA;
         isf_pkg::ST_DATA: if (b_valid && win_beat && b_eol) nxt_st = isf_pkg::ST_ECODE;
         isf_pkg::ST_ECODE: nxt_st = isf_pkg::ST_EID;
         isf_pkg::ST_EID: nxt_st = isf_pkg::ST_IDLE;
         // codes 4 and 5 are unused; recover to idle
         default: nxt_st = isf_pkg::ST_IDLE;
      endcase
   end

   // state advances only on word slots
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         st_ff <= isf_pkg::ST_IDLE;
      end else if (slot) begin
         st_ff <= nxt_st;
      end
   end

   // window id latched at line start, frame-edge choice latched at line start and end
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         id_ff <= 3'h0;
         frame_edge_ff <= 1'b0;
      end else if (slot && start_line) begin
         id_ff <= isf_pkg::top_win(b_mask);
         frame_edge_ff <= b_top;
      end else if (slot && (st_ff == isf_pkg::ST_DATA) && b_valid && win_beat && b_eol) begin
         frame_edge_ff <= b_bot;
      end
   end

   // lane and sync words, updated together so sync describes its data
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         lane0_out <= isf_pkg::RST_TRAIN;
         lane1_out <= isf_pkg::RST_TRAIN;
         lane2_out <= isf_pkg::RST_TRAIN;
         lane3_out <= isf_pkg::RST_TRAIN;
         sync_out <= isf_pkg::RST_IDLE;
      end else if (slot) begin
         if (send_beat) begin
            lane0_out <= isf_pkg::fit(b_pix[9:0], narrow_ff);
            lane1_out <= isf_pkg::fit(b_pix[19:10], narrow_ff);
            lane2_out <= isf_pkg::fit(b_pix[29:20], narrow_ff);
            lane3_out <= isf_pkg::fit(b_pix[39:30], narrow_ff);
            sync_out <= isf_pkg::fit(class_code, narrow_ff);
         end else begin
            lane0_out <= isf_pkg::fit(cfg_train_ff, narrow_ff);
            lane1_out <= isf_pkg::fit(cfg_train_ff, narrow_ff);
            lane2_out <= isf_pkg::fit(cfg_train_ff, narrow_ff);
            lane3_out <= isf_pkg::fit(cfg_train_ff, narrow_ff);
            unique case (st_ff)
               isf_pkg::ST_SCODE: sync_out <= isf_pkg::fmt_sync(frame_edge_ff ? isf_pkg::CODE_FS :
                                             isf_pkg::CODE_LS, cfg_marker_ff, narrow_ff);
               isf_pkg::ST_ECODE: sync_out <= isf_pkg::fmt_sync(frame_edge_ff ? isf_pkg::CODE_FE :
                                             isf_pkg::CODE_LE, cfg_marker_ff, narrow_ff);
               isf_pkg::ST_SID, isf_pkg::ST_EID: sync_out <= isf_pkg::fmt_id(id_ff, narrow_ff);
               default: sync_out <= isf_pkg::fit(cfg_idle_ff, narrow_ff);
            endcase
         end
      end
   end

   // forwarded clock: one half period per word slot
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         fwd_clk_out <= 1'b0;
      end else if (slot) begin
         fwd_clk_out <= ~fwd_clk_out;
      end
   end

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!reset_n_in);

   a_fs_code_wide: assert property ((slot && st_ff == isf_pkg::ST_SCODE && frame_edge_ff && !narrow_ff)
      |=> sync_out == {3'h5, cfg_marker_ff}) else $error("frame start word wrong");
   a_le_code_narrow: assert property ((slot && st_ff == isf_pkg::ST_ECODE && !frame_edge_ff && narrow_ff)
      |=> sync_out == {2'h0, 3'h2, cfg_marker_ff[6:2]}) else $error("narrow line end word wrong");
   a_id_follows: assert property ((slot && st_ff == isf_pkg::ST_SID)
      |=> sync_out == isf_pkg::fmt_id(id_ff, narrow_ff)) else $error("window id word not after code");
   a_top_window: assert property ((slot && start_line) |=> id_ff == isf_pkg::top_win($past(b_mask)))
      else $error("window id is not the highest");
   a_idle_train: assert property ((slot && !send_beat && st_ff == isf_pkg::ST_IDLE && !narrow_ff)
      |=> lane3_out == cfg_train_ff && sync_out == cfg_idle_ff) else $error("idle pattern wrong");
   a_valid_class: assert property ((slot && send_beat && b_kind == isf_pkg::KIND_VALID && !narrow_ff)
      |=> sync_out == cfg_valid_ff && lane0_out == $past(b_pix[9:0])) else $error("pixel class wrong");
   a_dark_no_code: assert property ((slot && st_ff == isf_pkg::ST_IDLE && b_valid && !win_beat)
      |=> st_ff == isf_pkg::ST_IDLE && b_ready == 1'b0) else $error("dark beat started a line");
   a_end_after_eol: assert property ((slot && st_ff == isf_pkg::ST_DATA && b_valid && win_beat && b_eol)
      |=> !slot [*1] ##[0:300] (slot && st_ff == isf_pkg::ST_ECODE)) else $error("no end code after last beat");
   a_narrow_depth: assert property ((slot && narrow_ff) |=> lane1_out[9:8] == 2'h0 && sync_out[9:8] == 2'h0)
      else $error("narrow word wider than eight bits");
   a_fwd_toggle: assert property (slot |=> fwd_clk_out != $past(fwd_clk_out))
      else $error("forwarded clock missed a slot");
endmodule

// file: dv/isf_rx_model.sv
// receiver model: decodes link words slot by slot
// assumes outputs of the framer change on the system clock edge
`timescale 1ns/1ps
module isf_rx_model (
   // clock
   input wire logic clk_sys_in,
   // link from the framer
   input wire logic fwd_clk_in,
   input wire logic [9:0] sync_in,
   input wire logic [9:0] lane0_in,
   input wire logic [9:0] lane3_in,
   // slot clock back to the framer
   output logic link_clk_out,
   // decoded words
   output logic word_stb_out,
   output logic [29:0] word_out
);
   logic fwd_seen_ff = 1'b0;
   logic locked_ff = 1'b0;

   // free-running slot clock, phase unrelated to the system clock
   initial begin
      link_clk_out = 1'b0;
      #37;
      forever #400 link_clk_out = ~link_clk_out;
   end

   // one word per forwarded clock toggle; nothing decoded before word lock
   always_ff @(posedge clk_sys_in) begin
      fwd_seen_ff <= fwd_clk_in;
      word_stb_out <= 1'b0;
      if (fwd_clk_in != fwd_seen_ff) begin
         if ((sync_in == 10'h3a6 && lane0_in == 10'h3a6) || (sync_in == 10'h0e9 && lane0_in == 10'h0e9)) begin
            locked_ff <= 1'b1;
         end
         if (locked_ff) begin
            word_stb_out <= 1'b1;
            word_out <= {sync_in, lane0_in, lane3_in};
         end
      end
   end
endmodule

// file: dv/isf_framer_bench.sv
// self-checking bench for the sync-lane framer
// assumes isf_rx_model as the far side and a free-running slot clock
`timescale 1ns/1ps
module isf_framer_bench;
   logic clk_sys_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic reg_wr_in = 1'b0;
   logic [7:0] reg_addr_in = 8'h00;
   logic [15:0] reg_wdata_in = 16'h0000;
   logic [15:0] reg_rdata_out;
   logic link_clk;
   logic pix_valid_in = 1'b0;
   logic pix_ready_out;
   logic [9:0] pix_lane [4] = '{10'h000, 10'h000, 10'h000, 10'h000};
   logic [1:0] pix_kind_in = 2'h1;
   logic [7:0] pix_win_mask_in = 8'h00;
   logic [3:0] pix_flags = 4'h0;
   logic [9:0] lane0_out, lane1_out, lane2_out, lane3_out, sync_out;
   logic fwd_clk_out;
   logic word_stb;
   logic [29:0] word;
   logic [29:0] q [$];
   logic narrow = 1'b0;
   logic [6:0] mark = 7'h2a;
   logic saw_stall = 1'b0;
   int fails = 0;
   int compares = 0;

   // clock stays at its normal rate in both word modes
   always #50 clk_sys_in = ~clk_sys_in;

   isf_framer dut_u (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .reg_wr_in(reg_wr_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
      .link_clk_in(link_clk), .pix_valid_in(pix_valid_in), .pix_ready_out(pix_ready_out),
      .pix_lane0_in(pix_lane[0]), .pix_lane1_in(pix_lane[1]), .pix_lane2_in(pix_lane[2]),
      .pix_lane3_in(pix_lane[3]), .pix_kind_in(pix_kind_in), .pix_win_mask_in(pix_win_mask_in),
      .pix_line_first_in(pix_flags[0]), .pix_line_last_in(pix_flags[1]), .pix_win_top_in(pix_flags[2]),
      .pix_win_bottom_in(pix_flags[3]), .lane0_out(lane0_out), .lane1_out(lane1_out), .lane2_out(lane2_out),
      .lane3_out(lane3_out), .sync_out(sync_out), .fwd_clk_out(fwd_clk_out));

   isf_rx_model rx_u (.clk_sys_in(clk_sys_in), .fwd_clk_in(fwd_clk_out), .sync_in(sync_out),
      .lane0_in(lane0_out), .lane3_in(lane3_out), .link_clk_out(link_clk), .word_stb_out(word_stb),
      .word_out(word));

   // collect decoded words and note any buffer refusal
   always @(posedge clk_sys_in) begin
      if (word_stb === 1'b1) q.push_back(word);
      if (reset_n_in && pix_valid_in && pix_ready_out === 1'b0) saw_stall = 1'b1;
   end

   task automatic results();
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [29:0] got, input logic [29:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // narrow mode keeps the upper eight bits of a ten-bit value
   function automatic logic [9:0] fitw(input logic [9:0] v);
      fitw = narrow ? {2'h0, v[9:2]} : v;
   endfunction

   function automatic logic [9:0] code_w(input logic [2:0] c);
      code_w = narrow ? {2'h0, c, mark[6:2]} : {c, mark};
   endfunction

   function automatic logic [9:0] id_w(input logic [2:0] id);
      id_w = narrow ? {5'h00, id, 2'h0} : {7'h00, id};
   endfunction

   task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
   endtask

   task automatic reg_read(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk_sys_in);
      reg_addr_in <= a;
      repeat (2) @(posedge clk_sys_in);
      #1 chk({14'h0, reg_rdata_out}, {14'h0, exp}, "register read");
   endtask

   // call just after an edge; holds the beat until the edge that takes it
   task automatic send_beat(input logic [1:0] kind, input logic [7:0] mask, input logic [3:0] flags,
                            input logic [9:0] base);
      int n;
      pix_valid_in <= 1'b1;
      pix_kind_in <= kind;
      pix_win_mask_in <= mask;
      pix_flags <= flags;
      for (int i = 0; i < 4; i++) pix_lane[i] <= base + 10'(i);
      n = 0;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (pix_ready_out !== 1'b1 && n < 200);
   endtask

   // next non-idle word from the receiver, bounded wait
   task automatic expect_word(input logic [9:0] s, input logic [9:0] l0, input logic [9:0] l3);
      logic [29:0] w;
      int n;
      n = 0;
      w = 30'h0;
      while (n < 400) begin
         if (q.size() > 0) begin
            w = q.pop_front();
            if (w[29:20] !== fitw(10'h3a6)) break;
         end else begin
            @(posedge clk_sys_in);
            n++;
         end
      end
      chk(w, {s, l0, l3}, "link word");
   endtask

   task automatic test_regs();
      logic [7:0] addrs [8] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h90};
      logic [15:0] vals [8] = '{16'h03a6, 16'h002a, 16'h0015, 16'h0035, 16'h0059, 16'h03a6, 16'h0000, 16'h0000};
      for (int i = 0; i < 8; i++) reg_read(addrs[i], vals[i]);
      reg_write(8'h90, 16'hffff);
      reg_read(8'h90, 16'h0000);
      reg_write(8'h83, 16'hffff);
      reg_read(8'h83, 16'h007f);
      reg_write(8'h83, 16'h002a);
   endtask

   // dark and checksum beats outside a line carry only their class code
   task automatic test_class();
      logic [1:0] kinds [2] = '{2'h0, 2'h2};
      logic [9:0] codes [2] = '{10'h015, 10'h059};
      for (int k = 0; k < 2; k++) begin
         @(posedge clk_sys_in);
         send_beat(kinds[k], 8'h00, 4'h0, 10'h2c0);
         pix_valid_in <= 1'b0;
         expect_word(fitw(codes[k]), fitw(10'h2c0), fitw(10'h2c3));
         chk({lane1_out, lane2_out, 10'h000}, {fitw(10'h2c1), fitw(10'h2c2), 10'h000}, "middle lanes");
      end
   endtask

   // one window line: flags are {bottom, top}
   task automatic run_line(input logic [7:0] mask, input logic [2:0] id, input int nb, input logic [1:0] tb);
      logic [9:0] tr;
      tr = fitw(10'h3a6);
      @(posedge clk_sys_in);
      for (int i = 0; i < nb; i++) begin
         send_beat(2'h1, mask, {tb, i == nb - 1, i == 0}, 10'h100 + 10'(i * 16));
      end
      pix_valid_in <= 1'b0;
      expect_word(code_w(tb[0] ? 3'h5 : 3'h1), tr, tr);
      expect_word(id_w(id), tr, tr);
      for (int i = 0; i < nb; i++) begin
         expect_word(fitw(10'h035), fitw(10'h100 + 10'(i * 16)), fitw(10'h103 + 10'(i * 16)));
      end
      expect_word(code_w(tb[1] ? 3'h6 : 3'h2), tr, tr);
      expect_word(id_w(id), tr, tr);
      repeat (24) @(posedge clk_sys_in);
      chk({sync_out, lane0_out, lane3_out}, {fitw(10'h3a6), tr, tr}, "idle after line");
   endtask

   // runaway guard, far beyond the expected few hundred cycles
   initial begin
      #2000000;
      fails++;
      $display("CHECK FAILED t=%0t watchdog expired", $time);
      results();
   end

   initial begin
      repeat (2) @(posedge clk_sys_in);
      reset_n_in <= 1'b1;
      repeat (30) @(posedge clk_sys_in);
      test_regs();
      test_class();
      run_line(8'h09, 3'h3, 2, 2'b01);
      saw_stall = 1'b0;
      run_line(8'h0a, 3'h3, 4, 2'b00);
      chk({29'h0, saw_stall}, 30'h1, "buffer never filled");
      run_line(8'h80, 3'h7, 1, 2'b11);
      reg_write(8'h83, 16'h0011);
      mark = 7'h11;
      run_line(8'h01, 3'h0, 2, 2'b10);
      reg_write(8'h88, 16'h0001);
      narrow = 1'b1;
      repeat (24) @(posedge clk_sys_in);
      q.delete();
      run_line(8'h06, 3'h2, 3, 2'b01);
      test_class();
      results();
   end
endmodule
